// ### hdl/sts_pkg.sv
// constants, fields and state type of the transaction scheduler
package sts_pkg;
    // ************************************************
    // timing
    // ************************************************
    localparam int TICK_MS = 10; // one step of every time setting
    localparam int CLK_PERIOD_NS = 100; // aclk at 10 MHz
    localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
    // ************************************************
    // register byte addresses
    // ************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TIME = 8'h04;
    localparam logic [7:0] A_TADR = 8'h08;
    localparam logic [7:0] A_TXD = 8'h0C;
    localparam logic [7:0] A_RXD = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_IST = 8'h18;
    localparam logic [7:0] A_IMSK = 8'h1C;
    // ************************************************
    // field positions
    // ************************************************
    localparam int C_EN = 0; // scanning enabled
    localparam int C_BC = 1; // entry belongs to the broadcaster
    localparam int C_COS = 2; // change-of-state-on-trigger mode
    localparam int C_FBO = 4; // fieldbus offline option, 2 bits
    localparam int C_SBO = 6; // subnetwork offline option
    localparam int T_GAP = 0; // broadcast gap, 8 bits
    localparam int T_REC = 8; // reconnect delay, 8 bits
    localparam int T_TO = 16; // response timeout, 8 bits
    localparam int T_RTY = 24; // retry limit, 4 bits
    localparam int TADR_W = 11; // trigger byte address width
    // offline option encodings
    localparam logic [1:0] FBO_CLEAR = 2'h0;
    localparam logic [1:0] FBO_FREEZE = 2'h1;
    localparam logic [1:0] FBO_HALT = 2'h2;
    localparam logic SBO_CLEAR = 1'h0;
    // interrupt bits and bus response codes
    localparam int I_RESP = 0;
    localparam int I_TOUT = 1;
    localparam int I_DISC = 2;
    localparam int I_BCST = 3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************
    // scheduler states, gray along idle-send-wait
    // ************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SEND = 3'h1,
        ST_WAIT = 3'h3,
        ST_GAP = 3'h2,
        ST_DISC = 3'h7
    } sts_state_t;
endpackage

// ### hdl/sts_scheduler.sv
// serial master transaction scheduler with AXI4-Lite registers
//
// Summary of operation
// [RL1] broadcaster holds off next entry after broadcast
// [RL2] all time settings count in 10 ms steps
// [RL3] fieldbus offline, clear: send zero payload
// [RL4] fieldbus offline, freeze: send last valid payload
// [RL5] fieldbus offline, halt option: stop issuing queries
// [RL6] subnetwork offline, clear: report zero data
// [RL7] subnetwork offline, freeze: keep last received data
// [RL8] wait reconnect delay before retrying disconnected node
// [RL9] consecutive timeouts reaching limit disconnect node
// [RL10] missing response within timeout is a timeout
// [RL11] resend the same query on each timeout
// [RL12] trigger address used only in trigger mode
// [RL13] query issued whenever trigger byte changes
// [RL14] valid response clears timeout count
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module sts_scheduler
    import sts_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC // cycles in one 10 ms step
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // higher level network status pin, asynchronous
    input wire logic fb_online,
    // subnetwork side, same clock
    output logic query_valid,
    output logic query_bcast,
    output logic [31:0] query_data,
    input wire logic resp_valid,
    input wire logic [31:0] resp_data,
    // data buffer side
    output logic [TADR_W-1:0] trig_addr,
    input wire logic [7:0] trig_byte,
    output logic [31:0] rx_out,
    // interrupt
    output logic irq
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [1:0] sync; // fb_online synchroniser
        sts_state_t st; // scheduler state
        logic [31:0] ctrl; // control register
        logic [31:0] timing; // time settings
        logic [TADR_W-1:0] tadr; // trigger byte address
        logic [31:0] txd; // payload from control system
        logic [31:0] hold; // last valid outgoing payload
        logic [31:0] rxd; // last received data
        logic [31:0] rx_out; // data shown to control system
        logic [31:0] pre; // step prescaler
        logic [7:0] units; // steps left in current wait
        logic [3:0] fails; // consecutive timeouts
        logic disc; // node disconnected
        logic [7:0] trig_last; // trigger byte at last issue
        logic q_valid; // query strobe
        logic q_bcast; // query is a broadcast
        logic [31:0] q_data; // query payload
        logic [3:0] ist; // sticky interrupt status
        logic [3:0] imask; // interrupt mask
        logic irq; // interrupt output
        logic awok; // write address held
        logic wok; // write data held
        logic [7:0] awa; // held write address
        logic [31:0] wd; // held write data
        logic [3:0] ws; // held strobes
        logic bvalid; // write response pending
        logic [1:0] bresp; // write response code
        logic arready; // read address ready
        logic rvalid; // read data pending
        logic [31:0] rdata; // read data
        logic [1:0] rresp; // read response code
        logic awready; // write address ready
        logic wready; // write data ready
    } sts_regs_t;

    sts_regs_t s;
    sts_regs_t next_s;
    // every check below runs on aclk and rests while reset is low
    default clocking sts_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // decoded settings and conditions
    logic fb_off; // higher level network offline
    logic halt; // scanning must stop
    logic trig_hit; // trigger condition satisfied
    logic tick; // one 10 ms step elapsed
    logic [1:0] fbo; // fieldbus offline option

    assign fb_off = !s.sync[1];
    assign fbo = s.ctrl[C_FBO +: 2];
    assign halt = fb_off && fbo == FBO_HALT; // RL5
    // the address only matters in trigger mode, otherwise any change
    // of the byte is ignored
    assign trig_hit = !s.ctrl[C_COS] || trig_byte != s.trig_last; // RL12 RL13
    assign tick = s.pre == 32'(TICK_CYCLES - 1);

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [31:0] wmask;
        logic [31:0] rv;
        logic [3:0] ev;
        logic rd_ist;
        wmask = '0;
        rv = '0;
        ev = '0;
        rd_ist = 1'b0;
        next_s = s;
        next_s.sync = {s.sync[0], fb_online};
        next_s.q_valid = 1'b0;
        // step prescaler, restarted on each wait load below
        next_s.pre = tick ? '0 : s.pre + 32'h1;
        if (tick && s.units != 8'h0) begin
            next_s.units = s.units - 8'h1; // RL2
        end
        // freeze keeps the last payload seen while online
        if (!fb_off) begin
            next_s.hold = s.txd; // RL4
        end
        case (s.st)
            ST_IDLE: begin
                // one attempt per scan once enabled
                if (s.ctrl[C_EN] && !halt && trig_hit) begin
                    next_s.st = ST_SEND; // RL13
                end
            end
            ST_SEND: begin
                if (halt) begin
                    next_s.st = ST_IDLE; // RL5
                end else begin
                    next_s.q_valid = 1'b1;
                    next_s.q_bcast = s.ctrl[C_BC];
                    next_s.trig_last = trig_byte;
                    if (!fb_off) begin
                        next_s.q_data = s.txd;
                    end else if (fbo == FBO_CLEAR) begin
                        next_s.q_data = '0; // RL3
                    end else begin
                        next_s.q_data = s.hold; // RL4
                    end
                    next_s.pre = '0;
                    if (s.ctrl[C_BC]) begin
                        next_s.st = ST_GAP; // RL1
                        next_s.units = s.timing[T_GAP +: 8]; // RL2
                    end else begin
                        next_s.st = ST_WAIT;
                        next_s.units = s.timing[T_TO +: 8]; // RL10
                    end
                end
            end
            ST_WAIT: begin
                if (resp_valid) begin
                    // a reply ends the timeout run and any disconnect
                    next_s.rxd = resp_data;
                    next_s.fails = '0; // RL14
                    next_s.disc = 1'b0; // RL14
                    next_s.st = ST_IDLE;
                    ev[I_RESP] = 1'b1;
                end else if (s.units == 8'h0) begin
                    ev[I_TOUT] = 1'b1; // RL10
                    next_s.fails = s.fails + 4'h1; // RL9
                    if (s.fails + 4'h1 >= s.timing[T_RTY +: 4]) begin
                        next_s.st = ST_DISC; // RL9
                        next_s.disc = 1'b1;
                        next_s.fails = '0;
                        next_s.pre = '0;
                        next_s.units = s.timing[T_REC +: 8]; // RL8
                        ev[I_DISC] = !s.disc;
                    end else begin
                        next_s.st = ST_SEND; // RL11
                    end
                end
            end
            ST_GAP: begin
                if (s.units == 8'h0) begin
                    next_s.st = ST_IDLE; // RL1
                    ev[I_BCST] = 1'b1;
                end
            end
            ST_DISC: begin
                // reconnect attempt is a fresh query once delay ran out
                if (s.units == 8'h0) begin
                    next_s.st = ST_SEND; // RL8
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        // subnetwork offline means the node is disconnected
        if (next_s.disc && s.ctrl[C_SBO] == SBO_CLEAR) begin
            next_s.rx_out = '0; // RL6
        end else if (!next_s.disc) begin
            next_s.rx_out = next_s.rxd;
        end
        // freeze leaves rx_out untouched while disconnected RL7

        // write channel: address and data taken in any order
        if (s_axi_awvalid && s.awready) begin
            next_s.awok = 1'b1;
            next_s.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.wok = 1'b1;
            next_s.wd = s_axi_wdata;
            next_s.ws = s_axi_wstrb;
        end
        if (s.awok && s.wok) begin
            for (int i = 0; i < 4; i++) begin
                wmask[i*8 +: 8] = {8{s.ws[i]}};
            end
            next_s.awok = 1'b0;
            next_s.wok = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OK;
            case (s.awa)
                A_CTRL: next_s.ctrl = (s.ctrl & ~wmask) | (s.wd & wmask);
                A_TIME: next_s.timing = (s.timing & ~wmask) | (s.wd & wmask);
                A_TADR: next_s.tadr = TADR_W'((32'(s.tadr) & ~wmask)
                    | (s.wd & wmask));
                A_TXD: next_s.txd = (s.txd & ~wmask) | (s.wd & wmask);
                A_IMSK: next_s.imask = 4'((32'(s.imask) & ~wmask)
                    | (s.wd & wmask));
                A_RXD, A_STAT, A_IST: begin
                end
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // read channel: one read at a time, answer the next cycle
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OK;
            case (s_axi_araddr)
                A_CTRL: rv = s.ctrl;
                A_TIME: rv = s.timing;
                A_TADR: rv = 32'(s.tadr);
                A_TXD: rv = s.txd;
                A_RXD: rv = s.rx_out;
                A_STAT: rv = {19'h0, s.disc, s.fails, 5'h0, s.st};
                A_IST: begin
                    rv = 32'(s.ist);
                    rd_ist = 1'b1;
                end
                A_IMSK: rv = 32'(s.imask);
                default: next_s.rresp = RESP_SLVERR;
            endcase
            next_s.rdata = rv;
        end
        next_s.arready = !next_s.rvalid;
        // readies registered so the bus sees flip-flop outputs only
        next_s.awready = !next_s.awok && !next_s.bvalid;
        next_s.wready = !next_s.wok && !next_s.bvalid;
        // read clears status, an event in the same cycle survives
        next_s.ist = (rd_ist ? 4'h0 : s.ist) | ev;
        next_s.irq = |(next_s.ist & next_s.imask);
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign query_valid = s.q_valid;
    assign query_bcast = s.q_bcast;
    assign query_data = s.q_data;
    assign trig_addr = s.tadr;
    assign rx_out = s.rx_out;
    assign irq = s.irq;

    // ************************************************
    // checks
    // ************************************************
    sequence s_send_bc;
        s.st == ST_SEND && s.ctrl[C_BC] && !halt;
    endsequence
    sequence s_timed_out;
        s.st == ST_WAIT && s.units == 8'h0 && !resp_valid;
    endsequence

    a_bcast_gap: assert property (s_send_bc // RL1
        |=> s.st == ST_GAP ##1 s.st != ST_SEND)
        else $error("broadcast not followed by gap");
    a_clear_zero: assert property (s.q_valid // RL3
        && $past(fb_off) && $past(fbo) == FBO_CLEAR |-> s.q_data == '0)
        else $error("clear option sent nonzero payload");
    a_freeze_hold: assert property (s.q_valid // RL4
        && $past(fb_off) && $past(fbo) == FBO_FREEZE
        |-> s.q_data == $past(s.hold))
        else $error("freeze option sent new payload");
    a_halt_stops: assert property (s.q_valid // RL5
        |-> !$past(halt))
        else $error("query issued while halted");
    // the option is taken from the cycle that loaded rx_out
    a_rx_clear: assert property (s.disc // RL6
        && $past(s.ctrl[C_SBO]) == SBO_CLEAR |-> s.rx_out == '0)
        else $error("offline data not cleared");
    a_rx_freeze: assert property (s.disc // RL7
        && $past(s.ctrl[C_SBO]) != SBO_CLEAR |-> $stable(s.rx_out))
        else $error("frozen data changed while offline");
    a_recon_wait: assert property (s.st == ST_DISC // RL8
        && s.units != 8'h0 |=> s.st == ST_DISC)
        else $error("reconnect before delay");
    a_timeout_act: assert property (s_timed_out // RL11
        |=> s.st == ST_SEND || s.st == ST_DISC)
        else $error("timeout not handled");
    a_disc_cause: assert property ($rose(s.disc) // RL9
        |-> $past(s.st) == ST_WAIT
        && $past(s.fails) + 4'h1 >= $past(s.timing[T_RTY +: 4]))
        else $error("disconnect without retry limit");
    a_fail_clear: assert property (s.st == ST_WAIT // RL14
        && resp_valid |=> s.fails == 4'h0 && !s.disc)
        else $error("response did not clear count");
    a_trig_idle: assert property (s.st == ST_IDLE // RL13
        && s.ctrl[C_COS] && trig_byte == s.trig_last
        |=> s.st == ST_IDLE)
        else $error("trigger mode issued without change");
endmodule
`default_nettype wire

// ### test/sts_slave_model.sv
// subnetwork slave model answering queries of the scheduler
`timescale 1ns/10ps
`default_nettype none
module sts_slave_model #(
    parameter int LAT = 3 // cycles from query to answer
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // query side
    input wire logic query_valid,
    input wire logic query_bcast,
    input wire logic [31:0] query_data,
    input wire logic mute, // stay silent to force timeouts
    // response side
    output logic resp_valid,
    output logic [31:0] resp_data
);
    int cnt = 0; // cycles left to the answer, 0 when idle
    logic [31:0] ans = 32'h0; // payload kept for the answer
    // ********
    // answer is the inverse of the query; a broadcast gets none
    // ********
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 0;
            resp_valid <= 1'h0;
            resp_data <= 32'h0;
        end else if (query_valid && !query_bcast && !mute) begin
            cnt <= LAT;
            ans <= ~query_data;
            resp_valid <= 1'h0;
            resp_data <= resp_data ^ 32'hA5A5_5A5A;
        end else if (cnt == 1) begin
            resp_valid <= 1'h1;
            resp_data <= ans;
            cnt <= 0;
        end else begin
            // data churns outside the answer so stale values never match
            resp_valid <= 1'h0;
            resp_data <= resp_data ^ 32'hA5A5_5A5A;
            if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/tb_serial_master_transaction_scheduler.sv
// self-checking bench of the transaction scheduler
`timescale 1ns/10ps
`default_nettype none
module tb_serial_master_transaction_scheduler;
    import sts_pkg::*;
    localparam int TK = 4; // short time step keeps waits brief
    // ********
    // signals
    // ********
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, query_valid, query_bcast, resp_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, query_data, resp_data, rx_out;
    logic fb_online = 1'h1;
    logic mute = 1'h0; // silences the slave
    logic [7:0] trig_byte = 8'h00;
    logic [TADR_W-1:0] trig_addr;
    int mismatches = 0, comparisons = 0;
    int seed = 65830; // fixed seed for payloads
    int cyc = 0, q_cyc = 0, q_gap = 0, q_cnt = 0; // query timing
    bit q_strict = 1'h1; // every query must have been noted
    logic [32:0] q_q[$]; // noted {broadcast, payload}
    logic [65:0] r_q[$]; // noted {mask, resp, data} of bus answers
    logic [31:0] d, dr;
    always #50 aclk = ~aclk;
    sts_scheduler #(.TICK_CYCLES(TK)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .fb_online, .query_valid,
        .query_bcast, .query_data, .resp_valid, .resp_data,
        .trig_addr, .trig_byte, .rx_out, .irq
    );
    sts_slave_model #(.LAT(3)) slave_u (
        .aclk, .aresetn, .query_valid, .query_bcast, .query_data,
        .mute, .resp_valid, .resp_data
    );
    // ********
    // tasks
    // ********
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("%0d compared, %0d mismatched", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // a wait that ran out ends the run as a mismatch
    task automatic hang();
        mismatches++;
        final_report();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er = RESP_OK);
        int n;
        r_q.push_back({32'h0, er, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 40) hang();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
                      input logic [31:0] m = 32'hFFFF_FFFF,
                      input logic [1:0] er = RESP_OK);
        int n;
        r_q.push_back({m, er, v});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        if (n == 40) hang();
    endtask
    task automatic wait_q(input int lim);
        int c0 = q_cnt;
        for (int n = 0; n < lim && q_cnt == c0; n++) @(negedge aclk);
        if (q_cnt == c0) hang();
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 40 && irq !== 1'h1; n++) @(negedge aclk);
        if (irq !== 1'h1) hang();
    endtask
    // control side steps the trigger byte after its data is in place
    task automatic bump(input logic [32:0] e);
        q_q.push_back(e);
        @(posedge aclk);
        trig_byte <= trig_byte + 8'h01;
    endtask
    task automatic span(input int lo, input int hi);
        chk(34'(q_gap >= lo && q_gap <= hi), 34'h1);
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'h0;
        trig_byte <= 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask
    // ********
    // monitor: takes the oldest note whenever a result appears
    // ********
    always @(posedge aclk) begin
        logic [65:0] e;
        logic [33:0] g, m;
        cyc <= cyc + 1;
        if (query_valid) begin
            q_gap <= cyc - q_cyc;
            q_cyc <= cyc;
            q_cnt <= q_cnt + 1;
            if (q_q.size() > 0) begin
                chk({1'h0, query_bcast, query_data}, {1'h0, q_q.pop_front()});
            end else if (q_strict) begin
                chk(34'h1, 34'h0);
            end
        end
        if ((s_axi_rvalid && s_axi_rready)
            || (s_axi_bvalid && s_axi_bready)) begin
            e = r_q.pop_front();
            m = {2'h3, e[65:34]};
            g = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
                : {s_axi_bresp, 32'h0};
            chk(g & m, e[33:0] & m);
        end
    end
    // ********
    // scenarios
    // ********
    initial begin
        do_reset();
        d = $random(seed);
        wr(A_TXD, d);
        rd(A_TXD, d);
        rd(A_IMSK, 32'h0);
        rd(8'h20, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(8'h24, d, RESP_SLVERR);
        wr(A_RXD, d);
        rd(A_RXD, 32'h0);
        wr(A_TADR, 32'h0000_05A3);
        @(negedge aclk);
        chk(34'(trig_addr), 34'h5A3);
        $display("registers done");
        wr(A_TIME, 32'h0302_0303);
        wr(A_IMSK, 32'h1);
        wr(A_CTRL, 32'h55);
        bump({1'h0, d});
        wait_q(40);
        wait_irq();
        chk(34'(rx_out ^ d), 34'h0_FFFF_FFFF);
        rd(A_IST, 32'h1, 32'hF);
        repeat (3) @(posedge aclk);
        chk(34'(irq), 34'h0);
        repeat (60) @(posedge aclk);
        $display("trigger query done");
        @(posedge aclk);
        mute <= 1'h1;
        dr = $random(seed);
        wr(A_TXD, dr);
        repeat (3) q_q.push_back({1'h0, dr});
        bump({1'h0, dr});
        wait_q(40);
        for (int i = 0; i < 2; i++) begin
            wait_q(40);
            span(2 * TK, 2 * TK + 4);
        end
        repeat (2 * TK + 3) @(posedge aclk);
        mute <= 1'h0;
        rd(A_STAT, 32'h1000, 32'h1000);
        chk(34'(rx_out ^ d), 34'h0_FFFF_FFFF);
        wait_q(60);
        span(5 * TK, 5 * TK + 6);
        wait_irq();
        rd(A_STAT, 32'h0, 32'h1F00);
        rd(A_IST, 32'h7, 32'hF);
        $display("retry and reconnect done");
        do_reset();
        wr(A_TIME, 32'h0102_C803);
        wr(A_IMSK, 32'h1);
        wr(A_TXD, d);
        wr(A_CTRL, 32'h15);
        bump({1'h0, d});
        wait_irq();
        @(posedge aclk);
        mute <= 1'h1;
        bump({1'h0, d});
        wait_q(40);
        repeat (2 * TK + 3) @(posedge aclk);
        chk(34'(rx_out), 34'h0);
        rd(A_STAT, 32'h1000, 32'h1000);
        do_reset();
        mute <= 1'h0;
        $display("subnetwork offline done");
        wr(A_TIME, 32'h0302_0303);
        wr(A_TXD, d);
        wr(A_CTRL, 32'h55);
        bump({1'h0, d});
        wait_q(40);
        repeat (8) @(posedge aclk);
        fb_online <= 1'h0;
        repeat (4) @(posedge aclk);
        wr(A_TXD, dr);
        bump({1'h0, d});
        wait_q(40);
        repeat (8) @(posedge aclk);
        wr(A_CTRL, 32'h45);
        bump({1'h0, 32'h0});
        wait_q(40);
        repeat (8) @(posedge aclk);
        wr(A_CTRL, 32'h65);
        @(posedge aclk);
        trig_byte <= trig_byte + 8'h01;
        repeat (60) @(posedge aclk);
        q_q.push_back({1'h0, dr});
        fb_online <= 1'h1;
        wait_q(40);
        $display("fieldbus offline done");
        repeat (8) @(posedge aclk);
        wr(A_CTRL, 32'h07);
        bump({1'h1, dr});
        wait_q(40);
        bump({1'h1, dr});
        wait_q(60);
        span(3 * TK, 3 * TK + 6);
        $display("broadcast done");
        @(posedge aclk);
        q_strict <= 1'h0;
        q_q.push_back({1'h0, dr});
        wr(A_CTRL, 32'h01);
        wait_q(60);
        $display("free scan done");
        final_report();
    end
endmodule
`default_nettype wire
